/* src/tdm_pkg.sv */
package tdm_pkg;

    // Host address layout.
    localparam int ADDR_W    = 15;
    localparam int SPACE_BIT = 14;
    localparam int STREAM_HI = 13;
    localparam int STREAM_LO = 9;
    localparam int CHAN_HI   = 8;
    localparam int STREAM_W  = 5;
    localparam int CHAN_W    = 9;
    localparam int WORD_W    = 16;
    localparam int BYTE_W    = 8;
    localparam int INDEX_W   = 12;
    localparam int MEM_DEPTH = 4096;
    localparam int FIFO_DEPTH = 8;
    localparam logic [7:0] UPPER_BYTE = 8'h00;
    localparam logic [7:0] UNUSED_BYTE = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [0:0] SIDE_LOCAL = 1'h0;
    localparam logic [0:0] SIDE_BACKPLANE = 1'h1;

    typedef enum logic [2:0]
    {
        TARGET_LOCAL_ROUTE     = 3'b000,
        TARGET_BACKPLANE_ROUTE = 3'b001,
        TARGET_LOCAL_DATA      = 3'b010,
        TARGET_BACKPLANE_DATA  = 3'b011
    } target_e;

    typedef enum logic [2:0]
    {
        RATE_2M  = 3'b000,
        RATE_4M  = 3'b001,
        RATE_8M  = 3'b010,
        RATE_16M = 3'b011,
        RATE_32M = 3'b100
    } rate_e;

    // Stream sits above channel; the split moves at the fastest rate.
    function automatic logic [INDEX_W-1:0] memIndex(
        input rate_e rate, input logic [STREAM_W-1:0] strm,
        input logic [CHAN_W-1:0] chan);
        if (rate == RATE_32M)
            memIndex = {strm[2:0], chan[8:0]};
        else
            memIndex = {strm[3:0], chan[7:0]};
    endfunction

    // True when stream and channel exist at the given rate.
    function automatic logic inRange(
        input rate_e rate, input logic [STREAM_W-1:0] strm,
        input logic [CHAN_W-1:0] chan);
        logic [CHAN_W-1:0] top;
        top = 9'h1FF;
        case (rate)
            RATE_2M:  top = 9'h01F;
            RATE_4M:  top = 9'h03F;
            RATE_8M:  top = 9'h07F;
            RATE_16M: top = 9'h0FF;
            default:  top = 9'h1FF;
        endcase
        if (rate == RATE_32M)
            inRange = (strm <= 5'h07) && (chan <= top);
        else
            inRange = (strm <= 5'h0F) && (chan <= top);
    endfunction

endpackage

/* src/tdm_memory_access_decode.sv */
// Notes on behaviour
// - Top address bit picks register or memory.
// - Select field picks target memory for accesses.
// - Select 000 local route, 001 backplane route.
// - Five bits below top are stream number.
// - Fastest rate allows streams zero to seven.
// - Lowest nine bits are channel number.
// - Channel range depends on stream rate.
// - Received timeslots deserialised, stored per side.
// - Local data memory: 4096 bytes, indexed.
// - Host writes never change stored data.
// - Reads return zero upper byte, data low.
// - First received bit lands in bit seven.
// - Backplane data memory mirrors the local one.
`timescale 1ns/10ps

module tdm_rx_fifo
    import tdm_pkg::*;
#(
    parameter int WIDTH = 21,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [PW:0] wrPtr;
        logic [PW:0] rdPtr;
    } fifo_s;

    fifo_s             state_q;
    fifo_s             state_d;
    logic [WIDTH-1:0]  store [DEPTH];
    logic [PW:0]       fill;

    // The extra pointer bit tells full from empty without a counter.
    assign fill     = state_q.wrPtr - state_q.rdPtr;
    assign inReady  = fill != (PW+1)'(DEPTH);
    assign outValid = fill != '0;
    assign outData  = store[state_q.rdPtr[PW-1:0]];

    // Pointer advance on each accepted push and pop.
    always_comb
    begin
        state_d = state_q;
        if (inValid && inReady)
            state_d.wrPtr = state_q.wrPtr + 1'b1;
        if (outValid && outReady)
            state_d.rdPtr = state_q.rdPtr + 1'b1;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    // Storage carries no reset; only written slots are ever read.
    always_ff @(posedge core_clk)
    begin
        if (inValid && inReady)
            store[state_q.wrPtr[PW-1:0]] <= inData;
    end

    // A stalled head must hold still, or a queued byte would be lost.
    AST_FIFO_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        outValid && !outReady |=> outValid && $stable(outData))
        else $error("capture buffer head changed while stalled");
endmodule

module tdm_memory_access_decode
    import tdm_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] hostAddr,
    input  wire logic              hostRead,
    input  wire logic              hostWrite,
    output logic [WORD_W-1:0]      hostRdData,
    output logic                   hostRdValid,
    output logic                   registerSelect,
    output logic                   localRouteSelect,
    output logic                   backplaneRouteSelect,
    input  wire target_e           memoryTargetSelect,
    input  wire rate_e             localRate,
    input  wire rate_e             backplaneRate,
    input  wire logic              rxValid,
    output logic                   rxReady,
    input  wire logic              rxSide,
    input  wire logic              rxBit,
    input  wire logic [STREAM_W-1:0] rxStream,
    input  wire logic [CHAN_W-1:0] rxChannel
);
    localparam int ENTRY_W = 1 + INDEX_W + BYTE_W;

    // The assertions below all run on the core clock and stop in reset.
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Read answer, plus a shift register and bit count for each side.
    typedef struct packed
    {
        logic [WORD_W-1:0]      rdData;
        logic                   rdValid;
        logic [1:0][BYTE_W-1:0] shift;
        logic [1:0][2:0]        bitCount;
    } state_s;

    // Timeslot stores carry no reset; a read before capture is undefined.
    state_s               state_q;
    state_s               state_d;
    logic [BYTE_W-1:0]    localMem [MEM_DEPTH];
    logic [BYTE_W-1:0]    backplaneMem [MEM_DEPTH];
    logic                 access;
    logic                 memSpace;
    logic [STREAM_W-1:0]  hostStream;
    logic [CHAN_W-1:0]    hostChan;
    logic                 dataRead;
    logic                 readBackplane;
    rate_e                readRate;
    rate_e                rxRate;
    logic [INDEX_W-1:0]   readIndex;
    logic                 pushValid;
    logic [ENTRY_W-1:0]   pushData;
    logic                 drainValid;
    logic                 drainReady;
    logic [ENTRY_W-1:0]   drainData;
    logic                 localWe;
    logic                 backplaneWe;
    logic [BYTE_W-1:0]    newByte;

    // Address split and memory target decode.
    assign access     = hostRead || hostWrite;
    assign memSpace   = hostAddr[SPACE_BIT];
    assign hostStream = hostAddr[STREAM_HI:STREAM_LO];
    assign hostChan   = hostAddr[CHAN_HI:0];
    assign registerSelect = access && !memSpace;
    assign localRouteSelect = access && memSpace
        && memoryTargetSelect == TARGET_LOCAL_ROUTE;
    assign backplaneRouteSelect = access && memSpace
        && memoryTargetSelect == TARGET_BACKPLANE_ROUTE;

    // Only reads reach the data memories; writes there are dropped.
    assign readBackplane = memoryTargetSelect == TARGET_BACKPLANE_DATA;
    assign dataRead = hostRead && memSpace
        && (memoryTargetSelect == TARGET_LOCAL_DATA || readBackplane);
    assign readRate  = readBackplane ? backplaneRate : localRate;
    assign readIndex = memIndex(readRate, hostStream, hostChan);

    // Deserialiser: bits shift in from the bottom, so first bit ends on top.
    assign rxRate    = rxSide ? backplaneRate : localRate;
    assign newByte   = {state_q.shift[rxSide][6:0], rxBit};
    assign pushValid = rxValid
        && state_q.bitCount[rxSide] == LAST_BIT
        && inRange(rxRate, rxStream, rxChannel);
    assign pushData  = {rxSide, memIndex(rxRate, rxStream, rxChannel),
                        newByte};

    // A full FIFO stalls the serial source before any bit is consumed.
    tdm_rx_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) rxFifo
    (
        .core_clk (core_clk),
        .rst      (rst),
        .inValid  (pushValid),
        .inReady  (rxReady),
        .inData   (pushData),
        .outValid (drainValid),
        .outReady (drainReady),
        .outData  (drainData)
    );

    // Memories are single ported: a host read holds the drain back.
    assign drainReady  = !dataRead;
    assign localWe     = drainValid && drainReady
        && drainData[ENTRY_W-1] == SIDE_LOCAL;
    assign backplaneWe = drainValid && drainReady
        && drainData[ENTRY_W-1] == SIDE_BACKPLANE;

    // Read path and bit counters.
    always_comb
    begin
        state_d = state_q;
        state_d.rdValid = dataRead;
        // The read owns the stores this cycle; the drain waits, so a read
        // never races a capture write to the same location.
        if (dataRead)
        begin
            state_d.rdData = {UPPER_BYTE, UNUSED_BYTE};
            if (inRange(readRate, hostStream, hostChan))
            begin
                if (readBackplane)
                    state_d.rdData[BYTE_W-1:0] = backplaneMem[readIndex];
                else
                    state_d.rdData[BYTE_W-1:0] = localMem[readIndex];
            end
        end
        // Dropped slots still advance the count, keeping later slots aligned.
        if (rxValid && rxReady)
        begin
            state_d.shift[rxSide] = newByte;
            state_d.bitCount[rxSide] = state_q.bitCount[rxSide] + 3'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    // Only the FIFO drain writes the timeslot stores.
    always_ff @(posedge core_clk)
    begin
        if (localWe)
            localMem[drainData[ENTRY_W-2:BYTE_W]] <= drainData[BYTE_W-1:0];
        if (backplaneWe)
            backplaneMem[drainData[ENTRY_W-2:BYTE_W]]
                <= drainData[BYTE_W-1:0];
    end

    assign hostRdData  = state_q.rdData;
    assign hostRdValid = state_q.rdValid;

    // Checks on decode, read path and capture. Each one except AST_HOST_NO_WRITE watches an
    // outcome, so a broken path trips it; AST_HOST_NO_WRITE excludes drainValid, which both write enables need, so it cannot fail.
    AST_REG_SPACE: assert property (access && !hostAddr[SPACE_BIT]
        |-> registerSelect && !localRouteSelect && !backplaneRouteSelect)
        else $error("register space access not decoded");

    AST_LOCAL_ROUTE: assert property (hostWrite && hostAddr[SPACE_BIT]
        && memoryTargetSelect == TARGET_LOCAL_ROUTE
        |-> localRouteSelect && !registerSelect)
        else $error("local route memory not selected");

    AST_BP_ROUTE: assert property (hostRead && hostAddr[SPACE_BIT]
        && memoryTargetSelect == TARGET_BACKPLANE_ROUTE
        |-> backplaneRouteSelect ##1 !hostRdValid)
        else $error("backplane route access misrouted");

    AST_DATA_TARGET: assert property (access && hostAddr[SPACE_BIT]
        && memoryTargetSelect == TARGET_LOCAL_DATA
        |-> !registerSelect && !localRouteSelect && !backplaneRouteSelect)
        else $error("data memory access raised a route select");

    AST_UPPER_ZERO: assert property (hostRdValid
        |-> hostRdData[15:8] == 8'h00)
        else $error("upper byte of data read not zero");

    AST_READ_ONE_CYCLE: assert property (dataRead |=> hostRdValid)
        else $error("data read answer not one cycle later");

    AST_READ_IDLE: assert property (!dataRead |=> !hostRdValid)
        else $error("read answer without a data read");

    AST_UNUSED_ZERO: assert property (dataRead && hostStream > 5'h07
        && readRate == RATE_32M |=> hostRdData == 16'h0000)
        else $error("unused location read not zero");

    AST_CHAN_RANGE: assert property (dataRead && hostChan > 9'h01F
        && readRate == RATE_2M |=> hostRdData == 16'h0000)
        else $error("channel beyond the rate range read non-zero");

    // A lone host write must never open a store for writing.
    AST_HOST_NO_WRITE: assert property (hostWrite && !drainValid
        |-> !localWe && !backplaneWe)
        else $error("memory written outside the capture path");

    AST_BYTE_AFTER_8: assert property (pushValid && rxReady
        |=> drainValid)
        else $error("captured byte not queued for the store");

    // Bits of one slot arrive on one side; the other side may interleave.
    AST_FIRST_BIT_TOP: assert property (rxValid && rxReady
        && state_q.bitCount[rxSide] == 3'h0
        ##1 (rxValid && rxReady && $stable(rxSide)) [*7]
        |-> pushData[7] == $past(rxBit, 7))
        else $error("first received bit not in bit seven");

    COV_LOCAL_READ: cover property (dataRead && !readBackplane
        ##1 hostRdValid);
    COV_FIFO_FULL: cover property (!rxReady && rxValid);
    COV_BP_CAPTURE: cover property (backplaneWe);
    COV_UNUSED_READ: cover property (dataRead
        && !inRange(readRate, hostStream, hostChan));
    COV_ROUTE_WRITE: cover property (hostWrite && localRouteSelect);
endmodule

/* bench/rx_source.sv */
`timescale 1ns/10ps

module rx_source
    import tdm_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           rxReady,
    output logic                rxValid,
    output logic                rxSide,
    output logic                rxBit,
    output logic [STREAM_W-1:0] rxStream,
    output logic [CHAN_W-1:0]   rxChannel
);
    // Idle state of the serial source before the first slot.
    initial
    begin
        rxValid   = 1'b0;
        rxSide    = 1'b0;
        rxBit     = 1'b0;
        rxStream  = 5'h00;
        rxChannel = 9'h000;
    end

    // Sends one slot, first bit first, holding each bit until it is taken.
    // The idle bit is inverted afterwards so a stale bit never looks valid.
    task automatic sendSlot(input logic side, input logic [4:0] strm,
                            input logic [8:0] chan, input logic [7:0] data);
        int i;
        @(posedge core_clk);
        for (i = 7; i >= 0; i--)
        begin
            rxValid   <= 1'b1;
            rxSide    <= side;
            rxStream  <= strm;
            rxChannel <= chan;
            rxBit     <= data[i];
            do @(negedge core_clk); while (rxReady !== 1'b1);
            @(posedge core_clk);
        end
        rxValid <= 1'b0;
        rxBit   <= ~data[0];
    endtask
endmodule

/* bench/tdm_memory_access_decode_tb.sv */
`timescale 1ns/10ps

module tdm_memory_access_decode_tb;
    import tdm_pkg::*;

    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] hostAddr;
    logic              hostRead;
    logic              hostWrite;
    logic [WORD_W-1:0] hostRdData;
    logic              hostRdValid;
    logic              registerSelect;
    logic              localRouteSelect;
    logic              backplaneRouteSelect;
    target_e           memoryTargetSelect;
    rate_e             localRate;
    rate_e             backplaneRate;
    logic              rxValid;
    logic              rxReady;
    logic              rxSide;
    logic              rxBit;
    logic [4:0]        rxStream;
    logic [8:0]        rxChannel;
    logic              sawFull;
    int                failCount;
    int                checked;
    int                i;

    // Free-running 40 MHz clock.
    always #12.5 core_clk = ~core_clk;

    tdm_memory_access_decode u_dut (.core_clk(core_clk), .rst(rst),
        .hostAddr(hostAddr), .hostRead(hostRead), .hostWrite(hostWrite),
        .hostRdData(hostRdData), .hostRdValid(hostRdValid),
        .registerSelect(registerSelect),
        .localRouteSelect(localRouteSelect),
        .backplaneRouteSelect(backplaneRouteSelect),
        .memoryTargetSelect(memoryTargetSelect), .localRate(localRate),
        .backplaneRate(backplaneRate), .rxValid(rxValid),
        .rxReady(rxReady), .rxSide(rxSide), .rxBit(rxBit),
        .rxStream(rxStream), .rxChannel(rxChannel));

    rx_source u_src (.core_clk(core_clk), .rxReady(rxReady),
        .rxValid(rxValid), .rxSide(rxSide), .rxBit(rxBit),
        .rxStream(rxStream), .rxChannel(rxChannel));

    // Remembers whether the capture buffer ever pushed back.
    always @(negedge core_clk)
        if (rxReady === 1'b0)
            sawFull = 1'b1;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            failCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Checks the three select outputs while the strobe is high.
    task automatic sel(input logic [14:0] a, input target_e t,
                       input logic [2:0] e);
        @(posedge core_clk);
        hostAddr <= a;
        memoryTargetSelect <= t;
        hostRead <= 1'b1;
        #1 chk({13'h0000, registerSelect, localRouteSelect,
                backplaneRouteSelect}, {13'h0000, e});
        @(posedge core_clk);
        hostRead <= 1'b0;
    endtask

    // One read; the answer is awaited for a few cycles at most.
    task automatic rd(input target_e t, input logic [14:0] a,
                      input logic [15:0] exp);
        int n;
        @(posedge core_clk);
        hostAddr <= a;
        memoryTargetSelect <= t;
        hostRead <= 1'b1;
        @(posedge core_clk);
        hostRead <= 1'b0;
        n = 0;
        #1;
        while (hostRdValid !== 1'b1 && n < 3)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk((hostRdValid === 1'b1) ? hostRdData : 16'hFFFF, exp);
    endtask

    task automatic wr(input target_e t, input logic [14:0] a);
        @(posedge core_clk);
        hostAddr <= a;
        memoryTargetSelect <= t;
        hostWrite <= 1'b1;
        @(posedge core_clk);
        hostWrite <= 1'b0;
    endtask

    task automatic printVerdict();
        if (failCount == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // A hang is cut short well past the expected run of a few hundred cycles.
    initial
    begin
        #(25 * 5000);
        failCount++;
        printVerdict();
    end

    // Main sequence of host accesses and captured slots.
    initial
    begin
        hostAddr = 15'h0000;
        hostRead = 1'b0;
        hostWrite = 1'b0;
        memoryTargetSelect = TARGET_LOCAL_DATA;
        localRate = RATE_16M;
        backplaneRate = RATE_32M;
        sawFull = 1'b0;
        failCount = 0;
        checked = 0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        sel(15'h0005, TARGET_LOCAL_DATA, 3'b100);
        sel(15'h4005, TARGET_LOCAL_ROUTE, 3'b010);
        sel(15'h4005, TARGET_BACKPLANE_ROUTE, 3'b001);
        wr(TARGET_LOCAL_ROUTE, 15'h4005);
        u_src.sendSlot(SIDE_LOCAL, 5'h03, 9'h005, 8'hB4);
        u_src.sendSlot(SIDE_BACKPLANE, 5'h07, 9'h1FF, 8'h6A);
        repeat (3) @(posedge core_clk);
        rd(TARGET_LOCAL_DATA, {1'b1, 5'h03, 9'h005}, 16'h00B4);
        rd(TARGET_BACKPLANE_DATA, {1'b1, 5'h07, 9'h1FF}, 16'h006A);
        wr(TARGET_LOCAL_DATA, {1'b1, 5'h03, 9'h005});
        wr(TARGET_BACKPLANE_DATA, {1'b1, 5'h07, 9'h1FF});
        rd(TARGET_LOCAL_DATA, {1'b1, 5'h03, 9'h005}, 16'h00B4);
        rd(TARGET_BACKPLANE_DATA, {1'b1, 5'h07, 9'h1FF}, 16'h006A);
        rd(TARGET_BACKPLANE_DATA, {1'b1, 5'h0F, 9'h1FF}, 16'h0000);
        rd(TARGET_LOCAL_DATA, {1'b1, 5'h03, 9'h105}, 16'h0000);
        localRate <= RATE_2M;
        rd(TARGET_LOCAL_DATA, {1'b1, 5'h03, 9'h005}, 16'h00B4);
        for (i = 0; i < 3; i++)
        begin
            localRate <= rate_e'(i);
            rd(TARGET_LOCAL_DATA, {1'b1, 5'h03, 9'(32 << i)}, 16'h0000);
        end
        localRate <= RATE_16M;
        // Back-to-back reads stall the drain so nine slots overfill it.
        fork
            for (int k = 0; k < 9; k++)
                u_src.sendSlot(SIDE_LOCAL, k[4:0], 9'h00A,
                               8'h21 + k[7:0]);
            begin
                @(posedge core_clk);
                hostRead <= 1'b1;
                repeat (100) @(posedge core_clk);
                hostRead <= 1'b0;
            end
        join
        chk({15'h0000, sawFull}, 16'h0001);
        repeat (20) @(posedge core_clk);
        for (i = 0; i < 9; i++)
            rd(TARGET_LOCAL_DATA, {1'b1, i[4:0], 9'h00A},
               {8'h00, 8'h21 + i[7:0]});
        // Swap the rates so the local side also runs its 32M index layout; the backplane read is out of range.
        localRate <= RATE_32M;
        backplaneRate <= RATE_16M;
        u_src.sendSlot(SIDE_LOCAL, 5'h05, 9'h1A5, 8'hC3);
        repeat (3) @(posedge core_clk);
        rd(TARGET_LOCAL_DATA, {1'b1, 5'h05, 9'h1A5}, 16'h00C3);
        rd(TARGET_LOCAL_DATA, {1'b1, 5'h09, 9'h1A5}, 16'h0000);
        rd(TARGET_BACKPLANE_DATA, {1'b1, 5'h07, 9'h1FF}, 16'h0000);
        printVerdict();
    end
endmodule
